/* File: pkg/eepc_pkg.sv */
// eepc_pkg: constants, field layouts and carriers for the eeprom program/erase control
package eepc_pkg;

  // bus geometry
  localparam int unsigned EEPC_ADDR_W = 12;
  localparam int unsigned EEPC_DATA_W = 32;
  localparam int unsigned EEPC_ARRAY_BYTES = 512;
  localparam int unsigned EEPC_ARRAY_AW = 9;
  localparam int unsigned EEPC_BLOCK_BYTES = 128;
  localparam int unsigned EEPC_BLOCKS = 4;

  // register byte offsets
  localparam logic [11:0] EEPC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] EEPC_OFS_NVCONFIG = 12'h004;
  localparam logic [11:0] EEPC_OFS_SHADOW = 12'h008;
  // array window: byte i of the array sits at EEPC_OFS_ARRAY + 4*i
  localparam logic [11:0] EEPC_OFS_ARRAY = 12'h800;
  localparam int unsigned EEPC_ARRAY_SEL_BIT = 11;

  // control register fields
  localparam int unsigned EEPC_CTL_PGM = 0;
  localparam int unsigned EEPC_CTL_LAT = 1;
  localparam int unsigned EEPC_CTL_RAS0 = 2;
  localparam int unsigned EEPC_CTL_RAS1 = 3;
  localparam int unsigned EEPC_CTL_OFF = 5;
  localparam int unsigned EEPC_CTL_BCLK = 7;

  // nonvolatile / shadow register fields
  localparam int unsigned EEPC_NV_BP_LSB = 0;
  localparam int unsigned EEPC_NV_SEC = 4;
  localparam int unsigned EEPC_NV_CON_LSB = 5;

  // reset and factory values
  localparam logic [7:0] EEPC_NV_FACTORY = 8'h10;
  localparam logic [7:0] EEPC_SHADOW_RESET = 8'h1f;
  localparam logic [7:0] EEPC_ERASED = 8'hff;

  // secured window: upper sixteen bytes of block 1 (array index 0x0f0..0x0ff)
  localparam logic [8:0] EEPC_SEC_LO = 9'h0f0;
  localparam logic [8:0] EEPC_SEC_HI = 9'h0ff;

  typedef enum logic [1:0] {
    EEPC_BYTE_PROGRAM = 2'b00,
    EEPC_BYTE_ERASE = 2'b01,
    EEPC_BLOCK_ERASE = 2'b10,
    EEPC_BULK_ERASE = 2'b11
  } eepc_mode_e;

  typedef struct packed {
    logic pump_clock_select;
    logic power_down;
    eepc_mode_e erase_select;
    logic latch_enable;
    logic program_enable;
  } eepc_ctrl_s;

  typedef struct packed {
    logic valid;
    logic is_nvr;
    logic [8:0] addr;
    logic [7:0] data;
  } eepc_latch_s;

endpackage : eepc_pkg

/* File: verilog/eepc_top.sv */
// eepc_top: eeprom program/erase control with apb register and array access
// Behaviour
// RULE1 - erased reads one; program only clears bits
// RULE2 - only unprotected array bytes and config writable
// RULE3 - host programs: latch, write, enable, wait, clear
// RULE4 - latch captures valid array writes, latest wins
// RULE5 - array reads return latched data while latching
// RULE6 - control writes ignored until valid array write
// RULE7 - program enable needs latch and captured write
// RULE8 - program enable runs pump and high voltage
// RULE9 - clearing enable and latch together clears enable
// RULE10 - erase mode frozen while program enable set
// RULE11 - block/bulk erase whole area, config untouched
// RULE12 - host erases: select, latch, write, enable, clear
// RULE13 - protected block never erased; bulk then void
// RULE14 - four 128-byte blocks, protect bits low first
// RULE15 - protected target gets no high voltage
// RULE16 - reset or config read reloads shadow register
// RULE17 - factory state: array erased, config bit4 one
// RULE18 - armed security blocks sixteen secured bytes
// RULE19 - armed security limits modes and config access
// RULE20 - armed security is permanent, config frozen
// RULE21 - pump clock select: bus clock or rc
// RULE22 - host picks rc below 8 mhz bus
// RULE23 - power down disables array, reset clears it
// RULE24 - erase select codes, reset to byte program
// RULE25 - latch cannot clear while enable set
// RULE26 - stop mode drops high voltage, keeps enable
// RULE27 - all wait times are timed by host
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module eepc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // factory initialisation of the nonvolatile cells, active low, asynchronous
  input wire logic factory_init_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eepc_pkg::EEPC_ADDR_W-1:0] paddr,
  input wire logic [eepc_pkg::EEPC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [eepc_pkg::EEPC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // system state
  input wire logic stop_mode,
  // analog and system controls
  output logic pump_enable,
  output logic high_voltage,
  output logic pump_clock_select,
  output logic array_power_down,
  output logic [2:0] mcu_config
);
  import eepc_pkg::*;

  // nonvolatile storage: only the factory init touches it, a system reset does not
  logic [7:0] mem [EEPC_ARRAY_BYTES];
  logic [7:0] nonvolatile_config;
  logic [7:0] array_config_shadow;
  eepc_ctrl_s eeprom_control;
  eepc_latch_s latched;
  logic shadow_load_pending;
  logic [EEPC_DATA_W-1:0] next_prdata;
  logic next_slverr;

  // decode helpers
  function automatic logic is_array(input logic [EEPC_ADDR_W-1:0] a);
    is_array = a[EEPC_ARRAY_SEL_BIT] && (a[1:0] == 2'b00);
  endfunction : is_array

  function automatic logic [8:0] array_index(input logic [EEPC_ADDR_W-1:0] a);
    array_index = a[10:2];
  endfunction : array_index

  function automatic logic [1:0] block_of(input logic [8:0] idx);
    block_of = idx[8:7];
  endfunction : block_of

  logic setup_phase;
  logic access_wr;
  logic access_rd;
  logic hit_ctrl;
  logic hit_nvr;
  logic hit_shadow;
  logic hit_array;
  logic sec_armed;
  logic [8:0] wr_index;
  logic wr_secured;
  logic wr_valid_array;
  logic wr_valid_nvr;
  logic byte_lane0;

  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign access_rd = psel && penable && !pwrite;
  assign hit_ctrl = (paddr == EEPC_OFS_CONTROL);
  assign hit_nvr = (paddr == EEPC_OFS_NVCONFIG);
  assign hit_shadow = (paddr == EEPC_OFS_SHADOW);
  assign hit_array = is_array(paddr);
  assign byte_lane0 = pstrb[0];
  assign wr_index = array_index(paddr);

  // RULE18 security armed
  // the live nonvolatile bit is used so that arming needs no reload to bite
  assign sec_armed = !nonvolatile_config[EEPC_NV_SEC];
  assign wr_secured = sec_armed && (wr_index >= EEPC_SEC_LO) && (wr_index <= EEPC_SEC_HI);

  // RULE19 secured bytes invalid
  assign wr_valid_array = hit_array && !wr_secured;
  // RULE2 config is a target
  assign wr_valid_nvr = hit_nvr && !sec_armed;

  // ---------------------------------------------------------------------
  // apb answer: data and error registered in setup, pready in access
  // ---------------------------------------------------------------------
  assign pready = psel && penable;

  always_comb begin
    next_prdata = '0;
    next_slverr = 1'b0;
    if (hit_ctrl) begin
      // the struct packs only six bits; bits 6 and 4 of the register read as zero
      next_prdata[7:0] = {eeprom_control.pump_clock_select, 1'b0,
                          eeprom_control.power_down, 1'b0,
                          eeprom_control.erase_select, eeprom_control.latch_enable,
                          eeprom_control.program_enable};
    end else if (hit_nvr) begin
      next_prdata[7:0] = nonvolatile_config;
    end else if (hit_shadow) begin
      next_prdata[7:0] = array_config_shadow;
    end else if (hit_array) begin
      // RULE23 array disabled
      // a powered down array has undefined contents; zero is returned
      if (eeprom_control.power_down) begin
        next_prdata[7:0] = 8'h00;
      // RULE5 latched data read
      end else if (eeprom_control.latch_enable) begin
        next_prdata[7:0] = latched.data;
      end else begin
        next_prdata[7:0] = mem[wr_index];
      end
    end else begin
      next_slverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? '0 : next_prdata;
      pslverr <= next_slverr;
    end
  end

  // ---------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------
  logic ctrl_write_ok;
  // RULE6 hold off control writes
  assign ctrl_write_ok = access_wr && hit_ctrl && byte_lane0 &&
                         !(eeprom_control.latch_enable && !latched.valid);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE24 erase select reset
      eeprom_control <= '0;
    end else if (ctrl_write_ok) begin
      // RULE21 pump clock source
      eeprom_control.pump_clock_select <= pwdata[EEPC_CTL_BCLK];
      eeprom_control.power_down <= pwdata[EEPC_CTL_OFF];
      // RULE10 mode frozen
      if (!eeprom_control.program_enable) begin
        eeprom_control.erase_select <= eepc_mode_e'({pwdata[EEPC_CTL_RAS1],
                                                      pwdata[EEPC_CTL_RAS0]});
      end
      // RULE25 latch held
      // RULE9 enable cleared first
      // latch only falls once enable is already low, giving the voltage time to decay
      if (!eeprom_control.program_enable) begin
        eeprom_control.latch_enable <= pwdata[EEPC_CTL_LAT];
      end
      // RULE7 enable interlock
      if (pwdata[EEPC_CTL_PGM]) begin
        if (eeprom_control.latch_enable && latched.valid) begin
          eeprom_control.program_enable <= 1'b1;
        end
      end else begin
        eeprom_control.program_enable <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // address/data latch
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= '0;
    end else if (!eeprom_control.latch_enable) begin
      latched <= '0;
    // RULE4 capture valid writes
    // later valid writes replace the target until program enable is set
    end else if (access_wr && byte_lane0 && !eeprom_control.program_enable &&
                 (wr_valid_array || wr_valid_nvr)) begin
      latched.valid <= 1'b1;
      latched.is_nvr <= wr_valid_nvr;
      latched.addr <= wr_index;
      latched.data <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // permission and high voltage
  // ---------------------------------------------------------------------
  logic [EEPC_BLOCKS-1:0] block_protect;
  logic op_allowed;
  logic erase_mode;
  logic latched_secured;

  // RULE14 protect bits by block
  assign block_protect = array_config_shadow[EEPC_NV_BP_LSB +: EEPC_BLOCKS];
  assign erase_mode = eeprom_control.erase_select != EEPC_BYTE_PROGRAM;
  assign latched_secured = sec_armed && (latched.addr >= EEPC_SEC_LO) &&
                           (latched.addr <= EEPC_SEC_HI);

  always_comb begin
    op_allowed = 1'b0;
    if (latched.valid) begin
      if (latched.is_nvr) begin
        // RULE20 config frozen
        // RULE11 config untouched
        op_allowed = !sec_armed && (eeprom_control.erase_select == EEPC_BYTE_PROGRAM ||
                                    eeprom_control.erase_select == EEPC_BYTE_ERASE);
      end else begin
        // RULE13 protected blocks
        // RULE19 block and bulk disabled
        case (eeprom_control.erase_select)
          EEPC_BYTE_PROGRAM: op_allowed = !block_protect[block_of(latched.addr)];
          EEPC_BYTE_ERASE: op_allowed = !block_protect[block_of(latched.addr)];
          EEPC_BLOCK_ERASE: op_allowed = !block_protect[block_of(latched.addr)] && !sec_armed;
          EEPC_BULK_ERASE: op_allowed = (block_protect == '0) && !sec_armed;
          default: op_allowed = 1'b0;
        endcase
        if (latched_secured) begin
          op_allowed = 1'b0;
        end
      end
    end
  end

  logic hv_on;
  // RULE8 pump and voltage
  // RULE15 protected gets none
  // RULE26 stop drops voltage
  assign hv_on = eeprom_control.program_enable && eeprom_control.latch_enable &&
                 op_allowed && !stop_mode && !eeprom_control.power_down;
  assign high_voltage = hv_on;
  assign pump_enable = hv_on;
  assign pump_clock_select = eeprom_control.pump_clock_select;
  assign array_power_down = eeprom_control.power_down;
  assign mcu_config = array_config_shadow[EEPC_NV_CON_LSB +: 3];

  // ---------------------------------------------------------------------
  // cell array: work is idempotent, so applying it every cycle the voltage
  // is on models an interrupted and resumed operation for free
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge factory_init_n) begin
    if (!factory_init_n) begin
      // RULE17 factory erased
      for (int i = 0; i < EEPC_ARRAY_BYTES; i++) begin
        mem[i] <= EEPC_ERASED;
      end
    end else if (hv_on && !latched.is_nvr) begin
      case (eeprom_control.erase_select)
        // RULE1 program clears bits
        EEPC_BYTE_PROGRAM: mem[latched.addr] <= mem[latched.addr] & latched.data;
        EEPC_BYTE_ERASE: mem[latched.addr] <= EEPC_ERASED;
        // RULE11 whole block erase
        EEPC_BLOCK_ERASE: begin
          for (int i = 0; i < EEPC_ARRAY_BYTES; i++) begin
            if (block_of(9'(i)) == block_of(latched.addr)) begin
              mem[i] <= EEPC_ERASED;
            end
          end
        end
        EEPC_BULK_ERASE: begin
          for (int i = 0; i < EEPC_ARRAY_BYTES; i++) begin
            mem[i] <= EEPC_ERASED;
          end
        end
        default: mem[latched.addr] <= mem[latched.addr];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge factory_init_n) begin
    if (!factory_init_n) begin
      // RULE17 config bit4 one
      nonvolatile_config <= EEPC_NV_FACTORY;
    end else if (hv_on && latched.is_nvr) begin
      if (eeprom_control.erase_select == EEPC_BYTE_ERASE) begin
        nonvolatile_config <= EEPC_ERASED;
      end else begin
        nonvolatile_config <= nonvolatile_config & latched.data;
      end
    end
  end

  // ---------------------------------------------------------------------
  // shadow of the nonvolatile register
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_load_pending <= 1'b1;
    end else begin
      shadow_load_pending <= 1'b0;
    end
  end

  // RULE16 reload shadow
  // during reset every block reads protected; the copy lands on the first edge after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_config_shadow <= EEPC_SHADOW_RESET;
    end else if (shadow_load_pending || (access_rd && hit_nvr)) begin
      array_config_shadow <= nonvolatile_config;
    end
  end

  // RULE27 host timed
  // no internal timer: program, erase and decay times are all the host's to keep

endmodule : eepc_top
`default_nettype wire

/* File: tb/eepc_monitor.sv */
// eepc_monitor: port-level assertions for the eeprom program/erase control
`timescale 1ns/100ps
`default_nettype none
module eepc_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic factory_init_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system
  input wire logic stop_mode,
  input wire logic pump_enable,
  input wire logic high_voltage,
  input wire logic pump_clock_select,
  input wire logic array_power_down,
  input wire logic [2:0] mcu_config
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bad_acc;
    psel && !penable && paddr == 12'h00c ##1 psel && penable;
  endsequence
  sequence s_ctl_acc;
    psel && !penable && paddr == 12'h000 ##1 psel && penable;
  endsequence
  chk_pump_hv_same: assert property (pump_enable == high_voltage)
    else $error("pump and voltage differ");
  chk_stop_hv_off: assert property (stop_mode |-> !high_voltage)
    else $error("voltage on in stop");
  chk_off_hv_off: assert property (array_power_down |-> !high_voltage)
    else $error("voltage on while powered down");
  chk_hv_rise_cause: assert property ($rose(high_voltage) |-> $past(stop_mode) ||
    $past(array_power_down) || $past(psel && penable && pwrite && paddr == 12'h000))
    else $error("voltage rose without cause");
  chk_cfg_reload: assert property ($changed(mcu_config) |-> !$past(presetn, 2) ||
    $past(psel && penable && !pwrite && paddr == 12'h004))
    else $error("config changed without reload");
  chk_unmapped_err: assert property (s_bad_acc |-> pslverr)
    else $error("unmapped access not refused");
  chk_ctl_no_err: assert property (s_ctl_acc |-> !pslverr)
    else $error("control access refused");
  chk_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_clk_sel_hold: assert property (!$past(psel && penable && pwrite) |->
    $stable(pump_clock_select))
    else $error("pump clock select moved");
endmodule : eepc_monitor
bind eepc_top eepc_monitor u_mon (.pclk, .presetn, .factory_init_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .stop_mode, .pump_enable,
  .high_voltage, .pump_clock_select, .array_power_down, .mcu_config);
`default_nettype wire

/* File: tb/eepc_host.sv */
// eepc_host: apb host model that steps the eeprom through its sequences
`timescale 1ns/100ps
`default_nettype none
module eepc_host (
  // clock
  input wire logic pclk,
  // request
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  output var logic [3:0] pstrb,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
endmodule : eepc_host
`default_nettype wire

/* File: tb/eepc_top_tb.sv */
// eepc_top_tb: scenario testbench for the eeprom program/erase control
`timescale 1ns/100ps
`default_nettype none
module eepc_top_tb;
  import eepc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic factory_init_n = 1'b0;
  logic stop_mode = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pump_enable, high_voltage;
  logic pump_clock_select, array_power_down;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [2:0] mcu_config;
  logic rerr;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 pclk = ~pclk;
  eepc_top dut (.pclk, .presetn, .factory_init_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .stop_mode, .pump_enable, .high_voltage,
    .pump_clock_select, .array_power_down, .mcu_config);
  eepc_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr);
  task summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // hang guard, well above the roughly five hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task chkd(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chkd
  task chkf(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chkf
  function automatic logic [11:0] aa(input int i);
    return EEPC_OFS_ARRAY + 12'(4 * i);
  endfunction : aa
  task rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    host.rd(a, rdat, rerr);
    chkd(rdat, e, m);
  endtask : rdc
  // full host sequence: latch, write, enable, wait, drop enable, drop latch
  task op(input logic [11:0] a, input logic [1:0] m, input logic [7:0] d, input logic hv);
    host.wr(12'h000, {28'h0, m, 2'b10});
    host.wr(a, {24'h0, d});
    host.wr(12'h000, {28'h0, m, 2'b11});
    #1 chkf(high_voltage, hv, "voltage on");
    repeat (4) @(posedge pclk);
    host.wr(12'h000, 32'h0);
    rdc(12'h000, {28'h0, m, 2'b10}, "ctl after drop");
    chkf(high_voltage, 1'b0, "voltage off");
    host.wr(12'h000, 32'h0);
  endtask : op
  task t_reset;
    rdc(12'h000, 32'h0, "ctl reset");
    rdc(12'h004, 32'h10, "nv factory");
    rdc(aa(3), 32'hff, "erased");
    host.rd(12'h00c, rdat, rerr);
    chkf(rerr, 1'b1, "unmapped");
    host.wr(12'h000, 32'h1);
    rdc(12'h000, 32'h0, "enable w/o latch");
    host.wr(12'h000, 32'h80);
    #1 chkf(pump_clock_select, 1'b1, "bus clock pump");
    host.wr(12'h000, 32'ha0);
    #1 chkf(array_power_down, 1'b1, "power down");
    rdc(12'h000, 32'ha0, "ctl readback");
    rdc(aa(3), 32'h0, "read powered down");
    host.wr(12'h000, 32'h0);
    #1 chkf(pump_clock_select, 1'b0, "rc pump");
    $display("reset test done");
  endtask : t_reset
  task t_program;
    host.wr(12'h000, 32'h02);
    host.wr(12'h000, 32'h82);
    rdc(12'h000, 32'h02, "ctl before capture");
    host.wr(aa(5), 32'hff);
    host.wr(aa(6), 32'h3c);
    rdc(aa(100), 32'h3c, "latched read");
    host.wr(12'h000, 32'h03);
    repeat (4) @(posedge pclk);
    host.wr(12'h000, 32'h0);
    host.wr(12'h000, 32'h0);
    rdc(aa(6), 32'h3c, "last capture");
    rdc(aa(5), 32'hff, "replaced capture");
    host.wr(12'h000, 32'h06);
    host.wr(aa(6), 32'h0);
    host.wr(12'h000, 32'h07);
    host.wr(12'h000, 32'h0d);
    rdc(12'h000, 32'h07, "mode and latch held");
    host.wr(12'h000, 32'h04);
    rdc(12'h000, 32'h06, "enable only cleared");
    host.wr(12'h000, 32'h0);
    rdc(aa(6), 32'hff, "byte erased");
    $display("program test done");
  endtask : t_program
  task t_erase;
    op(aa(6), EEPC_BYTE_PROGRAM, 8'h3c, 1'b1);
    op(aa(16), EEPC_BLOCK_ERASE, 8'h00, 1'b1);
    rdc(aa(6), 32'hff, "block erased");
    op(aa(400), EEPC_BYTE_PROGRAM, 8'h00, 1'b1);
    op(aa(0), EEPC_BULK_ERASE, 8'h00, 1'b1);
    rdc(aa(400), 32'hff, "bulk erased");
    rdc(12'h004, 32'h10, "nv untouched");
    $display("erase test done");
  endtask : t_erase
  task t_protect;
    op(EEPC_OFS_NVCONFIG, EEPC_BYTE_ERASE, 8'h00, 1'b1);
    rdc(12'h004, 32'hff, "nv erased");
    #1 chkd({29'h0, mcu_config}, 32'h7, "config reload");
    op(aa(0), EEPC_BYTE_PROGRAM, 8'h00, 1'b0);
    rdc(aa(0), 32'hff, "protected kept");
    op(aa(300), EEPC_BULK_ERASE, 8'h00, 1'b0);
    op(EEPC_OFS_NVCONFIG, EEPC_BYTE_PROGRAM, 8'h12, 1'b1);
    rdc(12'h004, 32'h12, "nv programmed");
    #1 chkd({29'h0, mcu_config}, 32'h0, "config cleared");
    op(aa(200), EEPC_BYTE_PROGRAM, 8'h00, 1'b0);
    op(aa(100), EEPC_BYTE_PROGRAM, 8'h5a, 1'b1);
    op(aa(0), EEPC_BULK_ERASE, 8'h00, 1'b0);
    rdc(aa(100), 32'h5a, "block0 programmed");
    rdc(aa(200), 32'hff, "block1 kept");
    $display("protect test done");
  endtask : t_protect
  task t_stop;
    host.wr(12'h000, 32'h02);
    host.wr(aa(9), 32'h0f);
    host.wr(12'h000, 32'h03);
    @(posedge pclk);
    stop_mode <= 1'b1;
    @(posedge pclk);
    #1 chkf(high_voltage, 1'b0, "stop cuts voltage");
    rdc(12'h000, 32'h03, "enable kept");
    stop_mode <= 1'b0;
    @(posedge pclk);
    #1 chkf(high_voltage, 1'b1, "voltage back");
    host.wr(12'h000, 32'h0);
    host.wr(12'h000, 32'h0);
    rdc(aa(9), 32'h0f, "programmed through stop");
    $display("stop test done");
  endtask : t_stop
  task t_secure;
    op(EEPC_OFS_NVCONFIG, EEPC_BYTE_PROGRAM, 8'h00, 1'b1);
    rdc(12'h004, 32'h0, "armed");
    op(aa(1), EEPC_BLOCK_ERASE, 8'h00, 1'b0);
    op(aa(1), EEPC_BYTE_PROGRAM, 8'h00, 1'b1);
    op(aa(1), EEPC_BYTE_ERASE, 8'h00, 1'b1);
    rdc(aa(1), 32'hff, "unsecured erase");
    host.wr(12'h000, 32'h02);
    host.wr(aa(245), 32'h0);
    host.wr(12'h000, 32'h03);
    #1 chkf(high_voltage, 1'b0, "secured no voltage");
    rdc(12'h000, 32'h02, "secured not latched");
    host.wr(aa(1), 32'hff);
    host.wr(12'h000, 32'h0);
    rdc(aa(245), 32'hff, "secured read");
    $display("secure test done");
  endtask : t_secure
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    factory_init_n <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_program();
    t_erase();
    t_protect();
    t_stop();
    t_secure();
    summarize();
  end
endmodule : eepc_top_tb
`default_nettype wire
